// File: verilog/vsb_bridge.sv
`timescale 1ns/1ps
`include "vsb_map.svh"

module vsb_fifo #(parameter int WIDTH = 36, parameter int DEPTH = 16) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : vsb_fifo

module vsb_bridge (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register bus, slave side
   input wire logic vme_as_n,
   input wire logic [1:0] vme_ds_n,
   input wire logic vme_write_n,
   input wire logic vme_lword_n,
   input wire logic vme_iack_n,
   input wire logic vme_iackin_n,
   input wire logic [5:0] vme_am,
   input wire logic [23:1] vme_addr,
   input wire logic [31:0] vme_data_in,
   output logic [31:0] vme_data_out,
   output logic vme_data_oe,
   output logic vme_dtack_oe,
   output logic vme_irq2_oe,
   // Back-plane links
   input wire logic [7:0] link_rx,
   output logic [7:0] link_tx,
   output logic link_clk,
   output logic backplane_sync,
   // External sync and switches
   input wire logic ext_sync_rx,
   input wire logic [5:0] id_switch_on,
   input wire logic mode_switch_on,
   input wire logic reset_switch_on,
   input wire logic ground_fault,
   // Auxiliary converter path
   input wire logic aux_sample_valid,
   input wire logic [2:0] aux_sample_index,
   input wire logic [15:0] aux_sample,
   output logic aux_convert_start,
   output logic aux_dac_load,
   output logic [2:0] aux_dac_index,
   output logic [9:0] aux_dac_value
);
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic logic is_read_cmd(input logic [3:0] c);
      is_read_cmd = (c >= 4'h1) && (c <= 4'h6);
   endfunction : is_read_cmd

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   vsb_pkg::vsb_bus_e bus, next_bus;
   logic [31:0] next_data_out;
   logic next_data_oe, next_dtack_oe, next_irq, wr_stb, rd_clear;
   logic [15:0] a16;
   logic [2:0] lnk;
   logic am_ok, data_cyc, iack_cyc, fifo_hit;
   logic [31:0] rd_word, aux_ext;
   logic [31:0] rmem [0:95];
   logic [15:0] amem [0:15];
   logic bank;
   logic [7:0] perr, tmo, next_perr, next_tmo, perr_set, tmo_set, good;
   logic [36:0] rx_full [8];
   logic [23:0] period, next_period, sync_cnt, next_sync_cnt;
   logic [1:0] sync_mode, data_mode, next_sync_mode, next_data_mode;
   vsb_pkg::vsb_data_e eff_mode;
   logic sync_ev, sync_pulse, ext_prev, ext_start;
   vsb_pkg::vsb_ext_s ext, next_ext;
   logic [63:0] sw_shift, next_sw_shift;
   logic [5:0] sw_cnt, next_sw_cnt;
   logic [31:0] sync_lo, sync_hi, next_sync_lo, next_sync_hi;
   logic [3:0] bit_div;
   logic bit_en;
   vsb_pkg::vsb_tx_s tx [8], next_tx [8];
   vsb_pkg::vsb_rx_s rxs [8], next_rxs [8];
   logic [7:0] bus_push, push_valid, push_ready, pop, f_valid;
   vsb_pkg::vsb_frame_s bus_word, fwd_word;
   vsb_pkg::vsb_frame_s f_data [8];
   logic fwd_active, next_fwd_active;
   logic [2:0] fwd_idx, next_fwd_idx;
   logic next_dac_load;
   logic [2:0] next_dac_index;
   logic [9:0] next_dac_value;

   // ------------------------------------------------------------
   // Register bus decode
   // ------------------------------------------------------------
   assign a16 = {vme_addr[15:1], 1'b0};
   assign lnk = a16[4:2];
   assign am_ok = (vme_am == `VSB_AM_NP_DATA) || (vme_am == `VSB_AM_NP_BLT) ||
                  (vme_am == `VSB_AM_SUP_DATA) || (vme_am == `VSB_AM_SUP_BLT);
   assign data_cyc = vme_iack_n && !vme_as_n && (vme_ds_n == 2'b00) && !vme_lword_n &&
                     am_ok;
   assign iack_cyc = !vme_iack_n && !vme_iackin_n && !vme_as_n && (vme_ds_n != 2'b11) &&
                     (vme_addr[3:1] == `VSB_IRQ_LEVEL) && vme_irq2_oe;
   assign fifo_hit = in_range(a16, `VSB_FIFO_FIRST, `VSB_REFRESH_LAST);
   assign eff_mode = mode_switch_on ? vsb_pkg::DATA_AUX : vsb_pkg::vsb_data_e'(data_mode);
   assign aux_ext = {{16{amem[{bank, lnk}][15]}}, amem[{bank, lnk}]};

   always_comb begin
      bus_word.cmd = a16[8:5] + 4'h1;
      bus_word.data = vme_data_in;
      if (in_range(a16, `VSB_REFRESH_FIRST, `VSB_REFRESH_LAST)) begin
         bus_word.cmd = vme_data_in[3:0];
         bus_word.data = 32'h0000_0000;
      end else if (in_range(a16, `VSB_SETPOINT_FIRST, `VSB_SETPOINT_LAST)) begin
         if (eff_mode == vsb_pkg::DATA_AUX) begin
            bus_word.data = aux_ext;
         end else if (eff_mode == vsb_pkg::DATA_SUM) begin
            bus_word.data = vme_data_in + aux_ext;
         end
      end
   end

   // Write-only and unmapped addresses read as zero.
   always_comb begin
      rd_word = 32'h0000_0000;
      if (a16 <= `VSB_RDMEM_LAST) begin
         rd_word = rmem[7'(a16[7:2]) + (bank ? 7'd0 : 7'd48)];
      end else if (a16 == `VSB_LINK_STATUS) begin
         rd_word = {`VSB_VERSION, 8'h00, perr, tmo};
      end else if (a16 == `VSB_SYNC_PERIOD) begin
         rd_word = {8'h00, period};
      end else if (a16 == `VSB_SYNC_LOW) begin
         rd_word = sync_lo;
      end else if (a16 == `VSB_SYNC_HIGH) begin
         rd_word = sync_hi;
      end else if (a16 == `VSB_AUX_MODE) begin
         rd_word = {19'h0, data_mode, sync_mode, reset_switch_on, ground_fault,
                    mode_switch_on, ~id_switch_on};
      end else if (a16 == `VSB_COUNTER_RB) begin
         rd_word = {1'b0, ext.ctrl, sync_cnt};
      end
   end

   always_comb begin
      next_bus = bus;
      next_data_out = vme_data_out;
      next_data_oe = vme_data_oe;
      next_dtack_oe = vme_dtack_oe;
      next_irq = vme_irq2_oe | sync_pulse;
      wr_stb = 1'b0;
      rd_clear = 1'b0;
      bus_push = 8'h00;
      case (bus)
         vsb_pkg::BUS_IDLE: begin
            if (iack_cyc) begin
               next_data_out = `VSB_IRQ_VECTOR;
               next_data_oe = 1'b1;
               next_dtack_oe = 1'b1;
               next_irq = sync_pulse;
               next_bus = vsb_pkg::BUS_ACK;
            end else if (data_cyc && !vme_write_n) begin
               // A full link queue holds off the acknowledge until a slot drains.
               if (!fifo_hit || (push_ready[lnk] && !fwd_active)) begin
                  wr_stb = 1'b1;
                  bus_push[lnk] = fifo_hit;
                  next_dtack_oe = 1'b1;
                  next_bus = vsb_pkg::BUS_ACK;
               end
            end else if (data_cyc) begin
               next_data_out = rd_word;
               next_data_oe = 1'b1;
               next_dtack_oe = 1'b1;
               rd_clear = (a16 == `VSB_LINK_STATUS);
               next_bus = vsb_pkg::BUS_ACK;
            end
         end
         vsb_pkg::BUS_ACK: begin
            if (vme_ds_n == 2'b11) begin
               next_data_oe = 1'b0;
               next_dtack_oe = 1'b0;
               next_bus = vsb_pkg::BUS_IDLE;
            end
         end
         default: next_bus = vsb_pkg::BUS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bus <= vsb_pkg::BUS_IDLE;
         vme_data_out <= 32'h0000_0000;
         vme_data_oe <= 1'b0;
         vme_dtack_oe <= 1'b0;
         vme_irq2_oe <= 1'b0;
      end else begin
         bus <= next_bus;
         vme_data_out <= next_data_out;
         vme_data_oe <= next_data_oe;
         vme_dtack_oe <= next_dtack_oe;
         vme_irq2_oe <= next_irq;
      end
   end

   // ------------------------------------------------------------
   // Control registers and SYNC generation
   // ------------------------------------------------------------
   always_comb begin
      next_period = period;
      next_sync_mode = sync_mode;
      next_data_mode = data_mode;
      if (wr_stb && a16 == `VSB_SYNC_PERIOD - `VSB_CSR_RD_DELTA) begin
         next_period = vme_data_in[23:0];
      end
      if (wr_stb && a16 == `VSB_AUX_MODE - `VSB_CSR_RD_DELTA) begin
         next_sync_mode = vme_data_in[`VSB_SYNC_MODE_LSB +: 2];
         next_data_mode = vme_data_in[`VSB_DATA_MODE_LSB +: 2];
      end
      next_sync_cnt = sync_cnt;
      sync_ev = 1'b0;
      case (vsb_pkg::vsb_sync_e'(sync_mode))
         vsb_pkg::SYNC_INT: begin
            if (sync_cnt <= 24'h1) begin
               next_sync_cnt = period;
               sync_ev = (period != 24'h0);
            end else begin
               next_sync_cnt = sync_cnt - 24'h1;
            end
         end
         vsb_pkg::SYNC_EXT: sync_ev = ext_start;
         vsb_pkg::SYNC_CPU: sync_ev = wr_stb && (a16 == `VSB_CPU_SYNC);
         default: sync_ev = 1'b0;
      endcase
      if (sync_mode != vsb_pkg::SYNC_INT) begin
         if (sync_ev) begin
            next_sync_cnt = period;
         end else if (sync_cnt != 24'h0) begin
            next_sync_cnt = sync_cnt - 24'h1;
         end
      end
      next_perr = (perr & ~{8{rd_clear}}) | perr_set;
      next_tmo = (tmo & ~{8{rd_clear}}) | tmo_set;
   end

   assign aux_convert_start = sync_pulse;
   assign backplane_sync = sync_pulse;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         period <= `VSB_PERIOD_RESET;
         sync_mode <= vsb_pkg::SYNC_CPU;
         data_mode <= vsb_pkg::DATA_BUS;
         sync_cnt <= 24'h0;
         sync_pulse <= 1'b0;
         bank <= 1'b0;
         perr <= 8'h00;
         tmo <= 8'h00;
      end else begin
         period <= next_period;
         sync_mode <= next_sync_mode;
         data_mode <= next_data_mode;
         sync_cnt <= next_sync_cnt;
         sync_pulse <= sync_ev;
         bank <= bank ^ sync_pulse;
         perr <= next_perr;
         tmo <= next_tmo;
      end
   end

   // ------------------------------------------------------------
   // External sync character and sync word
   // ------------------------------------------------------------
   assign ext_start = !ext.busy && ext_prev && !ext_sync_rx;

   always_comb begin
      next_ext = ext;
      next_sw_shift = sw_shift;
      next_sw_cnt = sw_cnt;
      next_sync_lo = sync_lo;
      next_sync_hi = sync_hi;
      if (ext_start) begin
         next_ext.busy = 1'b1;
         next_ext.idx = 4'h0;
         next_ext.div = 9'(`VSB_EXT_BIT_CYC + `VSB_EXT_BIT_CYC / 2);
      end else if (ext.busy && ext.div != 9'h0) begin
         next_ext.div = ext.div - 9'h1;
      end else if (ext.busy) begin
         next_ext.div = 9'(`VSB_EXT_BIT_CYC - 1);
         next_ext.idx = ext.idx + 4'h1;
         if (ext.idx < 4'h7) begin
            next_ext.ctrl[ext.idx[2:0]] = ext_sync_rx;
         end else if (ext.idx == 4'h7) begin
            next_sw_shift = {sw_shift[62:0], ext_sync_rx};
            next_sw_cnt = sw_cnt + 6'h1;
            if (sw_cnt == 6'h3f) begin
               next_sync_lo = next_sw_shift[31:0];
               next_sync_hi = next_sw_shift[63:32];
            end
         end else if (ext.idx == 4'h9) begin
            // Parity and stop times are skipped so they never look like a start.
            next_ext.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ext <= '0;
         ext_prev <= 1'b1;
         sw_shift <= 64'h0;
         sw_cnt <= 6'h0;
         sync_lo <= 32'h0;
         sync_hi <= 32'h0;
      end else begin
         ext <= next_ext;
         ext_prev <= ext_sync_rx;
         sw_shift <= next_sw_shift;
         sw_cnt <= next_sw_cnt;
         sync_lo <= next_sync_lo;
         sync_hi <= next_sync_hi;
      end
   end

   // ------------------------------------------------------------
   // Link queues, serial links and stand-alone forwarding
   // ------------------------------------------------------------
   assign fwd_word.cmd = 4'h9;
   assign fwd_word.data = {{16{amem[{bank, fwd_idx}][15]}}, amem[{bank, fwd_idx}]};

   generate
      for (genvar g = 0; g < 8; g++) begin : g_link
         assign push_valid[g] = bus_push[g] || (fwd_active && fwd_idx == 3'(g));
         assign link_tx[g] = tx[g].shreg[39];
         vsb_fifo #(.WIDTH(36), .DEPTH(`VSB_LINK_FIFO_DEPTH)) u_fifo (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .in_valid(push_valid[g]),
            .in_ready(push_ready[g]),
            .in_data(fwd_active ? fwd_word : bus_word),
            .out_valid(f_valid[g]),
            .out_ready(pop[g]),
            .out_data(f_data[g])
         );
      end
   endgenerate

   always_comb begin
      bit_en = (bit_div == 4'h0);
      next_fwd_active = fwd_active;
      next_fwd_idx = fwd_idx;
      if (sync_pulse && mode_switch_on) begin
         next_fwd_active = 1'b1;
         next_fwd_idx = 3'h0;
      end else if (fwd_active && push_ready[fwd_idx]) begin
         next_fwd_idx = fwd_idx + 3'h1;
         next_fwd_active = (fwd_idx != 3'h7);
      end
      next_dac_load = 1'b0;
      next_dac_index = aux_dac_index;
      next_dac_value = aux_dac_value;
      for (int i = 0; i < 8; i++) begin
         next_tx[i] = tx[i];
         next_rxs[i] = rxs[i];
         pop[i] = 1'b0;
         perr_set[i] = 1'b0;
         tmo_set[i] = 1'b0;
         good[i] = 1'b0;
         rx_full[i] = {rxs[i].shreg, link_rx[i]};
         if (rxs[i].pend) begin
            next_rxs[i].wait_cnt = rxs[i].wait_cnt + 12'h1;
            if (rxs[i].wait_cnt == 12'(`VSB_TIMEOUT_CYC)) begin
               tmo_set[i] = 1'b1;
               next_rxs[i].pend = 1'b0;
            end
         end
         if (bit_en) begin
            if (!tx[i].busy && f_valid[i]) begin
               pop[i] = 1'b1;
               next_tx[i].busy = 1'b1;
               next_tx[i].cnt = 6'h0;
               next_tx[i].shreg = {1'b1, f_data[i].cmd, f_data[i].data,
                                   ~^{f_data[i].cmd, f_data[i].data}, 2'b00};
               if (is_read_cmd(f_data[i].cmd)) begin
                  next_rxs[i].pend = 1'b1;
                  next_rxs[i].wait_cnt = 12'h0;
               end
            end else if (tx[i].busy) begin
               next_tx[i].shreg = {tx[i].shreg[38:0], 1'b0};
               next_tx[i].cnt = tx[i].cnt + 6'h1;
               next_tx[i].busy = (tx[i].cnt != 6'(`VSB_FRAME_BITS - 1));
            end
            if (!rxs[i].busy && link_rx[i]) begin
               next_rxs[i].busy = 1'b1;
               next_rxs[i].cnt = 6'h0;
            end else if (rxs[i].busy) begin
               next_rxs[i].shreg = rx_full[i][35:0];
               next_rxs[i].cnt = rxs[i].cnt + 6'h1;
               if (rxs[i].cnt == 6'(`VSB_REPLY_BITS - 1)) begin
                  next_rxs[i].busy = 1'b0;
                  next_rxs[i].pend = 1'b0;
                  good[i] = ^rx_full[i];
                  perr_set[i] = !(^rx_full[i]);
               end
            end
         end
      end
      for (int i = 7; i >= 0; i--) begin
         if (good[i] && mode_switch_on && rx_full[i][36:33] == 4'h1) begin
            next_dac_load = 1'b1;
            next_dac_index = 3'(i);
            next_dac_value = {~rx_full[i][24], rx_full[i][23:15]};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bit_div <= 4'h0;
         link_clk <= 1'b0;
         fwd_active <= 1'b0;
         fwd_idx <= 3'h0;
         aux_dac_load <= 1'b0;
         aux_dac_index <= 3'h0;
         aux_dac_value <= 10'h000;
         for (int i = 0; i < 8; i++) begin
            tx[i] <= '0;
            rxs[i] <= '0;
         end
      end else begin
         bit_div <= bit_en ? 4'(`VSB_LINK_BIT_CYC - 1) : bit_div - 4'h1;
         link_clk <= (bit_div > 4'(`VSB_LINK_BIT_CYC / 2));
         fwd_active <= next_fwd_active;
         fwd_idx <= next_fwd_idx;
         aux_dac_load <= next_dac_load;
         aux_dac_index <= next_dac_index;
         aux_dac_value <= next_dac_value;
         for (int i = 0; i < 8; i++) begin
            tx[i] <= next_tx[i];
            rxs[i] <= next_rxs[i];
         end
      end
   end

   // Banked memories need no reset; software only trusts them after a SYNC.
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 8; i++) begin
         if (good[i] && is_read_cmd(rx_full[i][36:33])) begin
            rmem[7'({rx_full[i][35:33] - 3'h1, 3'(i)}) + (bank ? 7'd48 : 7'd0)] <=
               rx_full[i][32:1];
         end
      end
      if (aux_sample_valid) begin
         amem[{~bank, aux_sample_index}] <= aux_sample;
      end
   end
endmodule : vsb_bridge

// File: verilog/vsb_map.svh
`ifndef VSB_MAP_SVH
`define VSB_MAP_SVH
// Address modifiers accepted on the register bus.
`define VSB_AM_NP_DATA 6'h39
`define VSB_AM_NP_BLT 6'h3b
`define VSB_AM_SUP_DATA 6'h3d
`define VSB_AM_SUP_BLT 6'h3f
// Register bus map, low sixteen address bits.
`define VSB_RDMEM_LAST 16'h00bc
`define VSB_FIFO_FIRST 16'h00e0
`define VSB_SETPOINT_FIRST 16'h0100
`define VSB_SETPOINT_LAST 16'h011c
`define VSB_REFRESH_FIRST 16'h0140
`define VSB_REFRESH_LAST 16'h015c
`define VSB_CSR_WR_FIRST 16'h0160
`define VSB_CSR_WR_LAST 16'h017c
`define VSB_CSR_RD_DELTA 16'h0020
`define VSB_LINK_STATUS 16'h0180
`define VSB_SYNC_PERIOD 16'h0184
`define VSB_SYNC_LOW 16'h0188
`define VSB_SYNC_HIGH 16'h018c
`define VSB_AUX_MODE 16'h0190
`define VSB_COUNTER_RB 16'h0198
`define VSB_CPU_SYNC 16'h01e0
// Interrupt acknowledge.
`define VSB_IRQ_LEVEL 3'h2
`define VSB_IRQ_VECTOR 32'h0000_0001
// Field positions in the mode and counter readback registers.
`define VSB_DATA_MODE_LSB 11
`define VSB_SYNC_MODE_LSB 9
`define VSB_CTRL_LSB 24
// Reset values.
`define VSB_VERSION 8'h01
`define VSB_PERIOD_RESET 24'h00_0000
// Timing.
`define VSB_SYS_CLK_HZ 20000000
`define VSB_LINK_BIT_HZ 2000000
`define VSB_LINK_BIT_CYC (`VSB_SYS_CLK_HZ / `VSB_LINK_BIT_HZ)
`define VSB_EXT_BAUD 115200
`define VSB_EXT_BIT_CYC (`VSB_SYS_CLK_HZ / `VSB_EXT_BAUD)
`define VSB_TIMEOUT_US 100
`define VSB_TIMEOUT_CYC (`VSB_TIMEOUT_US * (`VSB_SYS_CLK_HZ / 1000000))
`define VSB_FRAME_BITS 40
`define VSB_REPLY_BITS 37
`define VSB_LINK_FIFO_DEPTH 16
`endif

// File: verilog/vsb_pkg.sv
package vsb_pkg;
   typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_ACK = 2'b01} vsb_bus_e;
   typedef enum logic [1:0] {
      SYNC_CPU = 2'b00, SYNC_EXT = 2'b01, SYNC_INT = 2'b10, SYNC_NONE = 2'b11
   } vsb_sync_e;
   typedef enum logic [1:0] {
      DATA_AUX = 2'b00, DATA_BUS = 2'b01, DATA_SUM = 2'b10, DATA_NONE = 2'b11
   } vsb_data_e;
   typedef struct packed {logic [3:0] cmd; logic [31:0] data;} vsb_frame_s;
   typedef struct packed {logic busy; logic [39:0] shreg; logic [5:0] cnt;} vsb_tx_s;
   typedef struct packed {
      logic busy; logic [35:0] shreg; logic [5:0] cnt; logic pend; logic [11:0] wait_cnt;
   } vsb_rx_s;
   typedef struct packed {
      logic busy; logic [8:0] div; logic [3:0] idx; logic [6:0] ctrl;
   } vsb_ext_s;
endpackage : vsb_pkg

// File: verif/vsb_bridge_sva.sv
`timescale 1ns/1ps
module vsb_bridge_sva (
   // Clock and reset
   input logic sys_clk,
   input logic rst_n,
   // Bus and switch inputs
   input logic vme_write_n,
   input logic vme_lword_n,
   input logic vme_iack_n,
   input logic [5:0] vme_am,
   input logic [23:1] vme_addr,
   input logic [5:0] id_switch_on,
   // Design outputs
   input logic [31:0] vme_data_out,
   input logic vme_dtack_oe,
   input logic vme_irq2_oe,
   input logic backplane_sync,
   input logic aux_convert_start
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   d32_only_a: assert property ($rose(vme_dtack_oe) |-> !$past(vme_lword_n))
      else $error("ack on narrow cycle");
   am_filter_a: assert property ($rose(vme_dtack_oe) && $past(vme_iack_n)
      |-> $past(vme_am) inside {6'h39, 6'h3b, 6'h3d, 6'h3f}) else $error("bad modifier");
   iack_vector_a: assert property ($rose(vme_dtack_oe) && !$past(vme_iack_n)
      |-> vme_data_out == 32'h1) else $error("wrong vector");
   irq_on_sync_a: assert property (backplane_sync |=> vme_irq2_oe)
      else $error("no interrupt");
   sync_width_a: assert property (backplane_sync |=> !backplane_sync)
      else $error("sync too wide");
   conv_start_a: assert property (backplane_sync |-> aux_convert_start)
      else $error("no conversion start");
   crate_id_a: assert property ($rose(vme_dtack_oe) && $past(vme_addr[15:1]) == 15'h00c8
      && $past(vme_write_n) |-> vme_data_out[5:0] == ~$past(id_switch_on)) else $error("id");
   version_a: assert property ($rose(vme_dtack_oe) && $past(vme_addr[15:1]) == 15'h00c0
      && $past(vme_write_n) |-> vme_data_out[31:24] == 8'h01) else $error("version");
   cover property ($rose(vme_dtack_oe) && !$past(vme_iack_n));
   cover property ($fell(vme_irq2_oe));
   cover property (backplane_sync);
endmodule : vsb_bridge_sva

// File: verif/vsb_master_model.sv
`timescale 1ns/1ps
module vsb_master_model (
   // Clock
   input logic sys_clk,
   // Master side of the bus
   output logic vme_as_n,
   output logic [1:0] vme_ds_n,
   output logic vme_write_n,
   output logic vme_lword_n,
   output logic vme_iack_n,
   output logic vme_iackin_n,
   output logic [5:0] vme_am,
   output logic [23:1] vme_addr,
   output logic [31:0] vme_data_in,
   // Slave answer
   input logic vme_dtack_oe,
   input logic [31:0] vme_data_out
);
   initial {vme_as_n, vme_ds_n, vme_iack_n, vme_iackin_n, vme_write_n} = 6'h3f;
   initial {vme_lword_n, vme_am, vme_addr, vme_data_in} = '0;
   task automatic xfer(input logic wr, lw, ik, input logic [5:0] m, input logic [23:0] a,
                       input logic [31:0] d, output logic [31:0] q, output logic ok);
      int n;
      @(negedge sys_clk);
      {vme_write_n, vme_lword_n, vme_iack_n, vme_iackin_n} = {!wr, !lw, !ik, !ik};
      {vme_am, vme_addr, vme_data_in} = {m, a[23:1], d};
      {vme_as_n, vme_ds_n} = 3'b000;
      ok = 1'b0;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge sys_clk);
         ok = vme_dtack_oe;
         q = vme_data_out;
      end
      @(negedge sys_clk);
      {vme_as_n, vme_ds_n} = 3'b111;
      // Released data shows the inverse, so a stale value is never taken as live.
      vme_data_in = ~d;
      for (n = 0; n < 5 && vme_dtack_oe; n++) @(negedge sys_clk);
   endtask : xfer
endmodule : vsb_master_model

// File: verif/vsb_bridge_test.sv
`timescale 1ns/1ps
module vsb_bridge_test;
   logic sys_clk, rst_n, vme_as_n, vme_write_n, vme_lword_n, vme_iack_n, vme_iackin_n, ok;
   logic vme_data_oe, vme_dtack_oe, vme_irq2_oe, link_clk, backplane_sync, ext_sync_rx;
   logic mode_switch_on, reset_switch_on, ground_fault, aux_sample_valid, aux_convert_start;
   logic aux_dac_load;
   logic [1:0] vme_ds_n;
   logic [2:0] aux_sample_index, aux_dac_index;
   logic [5:0] vme_am, id_switch_on;
   logic [5:0] ams [4] = '{6'h39, 6'h3b, 6'h3d, 6'h3f};
   logic [7:0] link_rx, link_tx;
   logic [9:0] aux_dac_value;
   logic [15:0] aux_sample;
   logic [23:1] vme_addr;
   logic [31:0] vme_data_in, vme_data_out, q, seed;
   int err_count, cmp_count, n;
   vsb_bridge dut (.*);
   vsb_master_model m (.*);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [31:0] aux_word(input logic [5:0] id, input logic r, g, md);
      return {19'h0, 2'b01, 2'b00, r, g, md, ~id};
   endfunction : aux_word
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : check_word
   task automatic wrap_up;
      $display("Counts: %0d compared, %0d mismatched", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic bus(input logic wr, input logic [23:0] a, input logic [31:0] d);
      m.xfer(wr, 1'b1, 1'b0, 6'h39, a, d, q, ok);
      if (!ok) begin
         err_count++;
         wrap_up();
      end
   endtask : bus
   task automatic wait_sync(output int c);
      c = 0;
      do begin
         @(negedge sys_clk);
         c++;
      end while (!backplane_sync && c < 3000);
      if (!backplane_sync) begin
         err_count++;
         wrap_up();
      end
   endtask : wait_sync
   task automatic reply(input logic [37:0] w);
      for (int b = 37; b >= 0; b--) begin
         link_rx[2] = w[b];
         repeat (10) @(negedge sys_clk);
      end
      link_rx[2] = 1'b0;
   endtask : reply
   initial begin
      {link_rx, ext_sync_rx, aux_sample_valid, aux_sample_index, aux_sample} = 29'h1_00000;
      rst_n = 1'b0;
      seed = lfsr(32'h5de0);
      {id_switch_on, mode_switch_on, reset_switch_on, ground_fault} = seed[8:0];
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      bus(1'b0, 24'h7f0180, 32'h0);
      check_word(q, 32'h0100_0000);
      bus(1'b0, 24'h000190, 32'h0);
      check_word(q, aux_word(id_switch_on, reset_switch_on, ground_fault, mode_switch_on));
      $display("status and switch reads done");
      seed = lfsr(seed);
      bus(1'b1, 24'h000164, seed);
      bus(1'b0, 24'h000184, 32'h0);
      check_word(q, {8'h0, seed[23:0]});
      bus(1'b0, 24'h000164, 32'h0);
      check_word(q, 32'h0);
      bus(1'b0, 24'h0001c8, 32'h0);
      check_word(q, 32'h0);
      m.xfer(1'b0, 1'b0, 1'b0, 6'h39, 24'h180, 32'h0, q, ok);
      check_word(32'(ok), 32'h0);
      m.xfer(1'b0, 1'b1, 1'b0, 6'h09, 24'h180, 32'h0, q, ok);
      check_word(32'(ok), 32'h0);
      foreach (ams[i]) begin
         m.xfer(1'b0, 1'b1, 1'b0, ams[i], 24'h180, 32'h0, q, ok);
         check_word(32'(ok), 32'h1);
      end
      $display("decode and refusal test done");
      bus(1'b1, 24'h000144, 32'h1);
      for (n = 0; n < 40 && !link_tx[1]; n++) @(negedge sys_clk);
      check_word(32'(link_tx[1]), 32'h1);
      repeat (15) @(negedge sys_clk);
      check_word(32'(link_tx[1]), 32'h0);
      repeat (30) @(negedge sys_clk);
      check_word(32'(link_tx[1]), 32'h1);
      repeat (2600) @(negedge sys_clk);
      bus(1'b0, 24'h000180, 32'h0);
      check_word(q, 32'h0100_0002);
      bus(1'b0, 24'h000180, 32'h0);
      check_word(q, 32'h0100_0000);
      $display("link timeout test done");
      bus(1'b1, 24'h0001e0, 32'h0);
      repeat (2) @(negedge sys_clk);
      check_word(32'(vme_irq2_oe), 32'h1);
      m.xfer(1'b0, 1'b1, 1'b1, 6'h39, 24'h000004, 32'h0, q, ok);
      check_word(q, 32'h1);
      check_word(32'(vme_irq2_oe), 32'h0);
      seed = lfsr(seed);
      reply({1'b1, 4'h3, seed, ~^{4'h3, seed}});
      bus(1'b1, 24'h0001e0, 32'h0);
      bus(1'b0, 24'h000048, 32'h0);
      check_word(q, seed);
      reply({1'b1, 4'h3, ~seed, ^{4'h3, seed}});
      bus(1'b0, 24'h000180, 32'h0);
      check_word(q, 32'h0100_0400);
      $display("cpu sync and interrupt test done");
      bus(1'b1, 24'h000164, 32'h9);
      bus(1'b1, 24'h0001e0, 32'h0);
      bus(1'b0, 24'h000198, 32'h0);
      check_word(32'(q[23:0] inside {[24'h1:24'h9]}), 32'h1);
      bus(1'b1, 24'h000170, 32'h0000_0c00);
      wait_sync(n);
      wait_sync(n);
      check_word(n, 32'd9);
      bus(1'b0, 24'h000198, 32'h0);
      check_word(32'(q[23:0] inside {[24'h1:24'h9]}), 32'h1);
      $display("internal sync test done");
      wrap_up();
   end
endmodule : vsb_bridge_test
bind vsb_bridge vsb_bridge_sva chk (.*);
